// *** core/trp_skid.sv ***
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module trp_skid #(
    parameter int W = 16,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk, // Clock
    input wire logic rst, // Async reset, high
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [W-1:0] in_data, // Word in
    output logic out_valid, // Word held
    input wire logic out_ready, // Receiver takes word
    output logic [W-1:0] out_data // Word out
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, rp_reg;
    logic [AW:0] fill_reg;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    assign in_ready = fill_reg != (AW+1)'(DEPTH);
    assign out_valid = fill_reg != '0;
    assign out_data = mem[rp_reg];
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wp_reg <= '0;
            rp_reg <= '0;
            fill_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
            end
            fill_reg <= fill_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// *** core/trp_top.sv ***
// Trace buffer read-out and code profiling output
`timescale 1ns/1ps
`default_nettype none
module trp_top #(
    parameter int LINES = trp_pkg::LINES
) (
    input wire logic ref_clk, // Bus clock
    input wire logic rst, // System reset, async high
    input wire logic por, // Power-on reset, async high
    input wire logic trace_source_select, // Trace source chosen
    input wire logic code_enable_a, // Code_enable_a enable
    input wire logic code_enable_a_pin_enable, // Drive code_enable_a pins
    input wire logic [1:0] trigger_alignment, // Alignment select
    input wire logic arm_req, // Software arm pulse
    input wire logic disarm_req, // Disarm pulse
    input wire logic final_state, // Sequencer final state pulse
    input wire trp_pkg::trp_cof_t change_of_flow, // Change of flow event
    input wire logic [23:0] pc_start, // Current PC
    input wire logic rd_req, // Read of trace_read_port
    input wire logic rd_word, // Read is word sized
    input wire logic rd_misaligned, // Read address odd
    output logic rd_ready, // Read can be taken
    output logic rd_valid, // Read data held
    input wire logic rd_accept, // Receiver takes data
    output logic [15:0] rd_data, // Read data
    input wire logic wr_req, // Write of trace_read_port
    input wire logic wr_word, // Write aligned word
    output logic armed, // Unit armed
    output logic transmit_active_flag, // Lines still to send
    output logic code_enable_a_overflow_flag, // Buffer overflowed
    output logic [6:0] valid_line_count, // Valid lines
    output logic code_enable_a_data_out, // Serial data
    output logic code_enable_a_clock_out, // Serial clock
    output logic code_enable_a_oe_n // Pin enable, low drives
);
    localparam int PW = trp_pkg::PTR_W;
    localparam int LW = trp_pkg::LINE_W;
    logic [LW-1:0] mem [LINES];
    trp_pkg::trp_state_t st_reg, st_next;
    logic armed_reg, lock_reg, ovf_reg;
    logic [PW:0] wp_reg, txp_reg;
    logic wrap_reg;
    logic [6:0] cnt_reg;
    logic [PW-1:0] rdp_reg;
    logic [1:0] half_reg;
    logic [31:0] dir_reg;
    logic [15:0] ts_reg;
    logic [LW-1:0] sh_reg;
    logic [6:0] bits_reg;
    logic phase_reg, clk_reg, pdo_reg, oe_n_reg;

    // Configuration decode
    wire prof_cfg = trace_source_select & code_enable_a;
    // Mid alignment falls through to end alignment
    wire align_begin = trigger_alignment == trp_pkg::ALIGN_BEGIN;
    wire [PW:0] pend = wp_reg - txp_reg;
    wire tx_busy = bits_reg != '0;
    wire tx_active = (pend != '0) | tx_busy;
    wire wr_block = ~armed_reg & tx_active;
    wire arm_ok = arm_req & ~armed_reg & ~wr_block;
    wire wr_ok = wr_req & wr_word & ~armed_reg & ~wr_block;

    // Profiling entry decode
    wire in_idle = st_reg == trp_pkg::ST_IDLE;
    wire in_wait = st_reg == trp_pkg::ST_WAIT;
    wire in_run = st_reg == trp_pkg::ST_RUN;
    wire go = armed_reg & prof_cfg;
    wire start_now = (in_idle & go & ~align_begin) |
        (in_wait & go & final_state);
    wire br = in_run & change_of_flow.branch;
    // Newest branch bit enters at bit zero, stop bit moves left
    wire [31:0] dir_in = br ? {dir_reg[30:0], change_of_flow.taken} : dir_reg;
    wire idx = in_run & change_of_flow.indexed;
    wire vec = in_run & change_of_flow.vector & ~change_of_flow.indexed;
    wire full = br & dir_reg[30];
    wire ts_ovf = in_run & (ts_reg == trp_pkg::STAMP_MAX);
    wire term = in_run & disarm_req;
    wire closing = idx | vec | full | ts_ovf | term;
    wire entry = start_now | (in_run & closing);
    wire ovf_hit = in_run & entry & (pend == trp_pkg::PEND_LAST);
    wire disarm_evt = armed_reg & (disarm_req | ovf_hit);

    // Info byte
    wire [3:0] fmt = start_now ? trp_pkg::FMT_START :
        idx ? trp_pkg::FMT_INDEXED :
        vec ? trp_pkg::FMT_VECTOR :
        full ? trp_pkg::FMT_FULL : trp_pkg::FMT_WRAPUP;
    wire [7:0] info = {1'b0, ts_ovf, ovf_hit, term, fmt};

    // Line assembly
    wire [LW-1:0] line_start = {32'h0000_0000, pc_start, info};
    wire [LW-1:0] line_idx = {change_of_flow.target, dir_in, info};
    wire [LW-1:0] line_vec = {change_of_flow.vec_addr, ts_reg, dir_in, info};
    wire [LW-1:0] line_full = {24'h00_0000, dir_in, info};
    wire [LW-1:0] line_wrap = {8'h00, ts_reg, dir_in, info};
    wire [LW-1:0] line_new = start_now ? line_start :
        idx ? line_idx :
        vec ? line_vec :
        full ? line_full : line_wrap;

    // State sequence
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            trp_pkg::ST_IDLE: begin
                if (go) begin
                    st_next = align_begin ? trp_pkg::ST_WAIT
                        : trp_pkg::ST_RUN;
                end
            end
            trp_pkg::ST_WAIT: begin
                if (!go) begin
                    st_next = trp_pkg::ST_IDLE;
                end else if (final_state) begin
                    st_next = trp_pkg::ST_RUN;
                end
            end
            trp_pkg::ST_RUN: begin
                // Runs until disarm, overflow or prof_cfg drops, no line limit
                if (disarm_evt || !prof_cfg) begin
                    st_next = trp_pkg::ST_IDLE;
                end
            end
            default: begin
                st_next = trp_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= trp_pkg::ST_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Arm, lock and overflow flag
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            armed_reg <= 1'b0;
            lock_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else begin
            if (arm_ok) begin
                armed_reg <= 1'b1;
            end else if (disarm_evt) begin
                armed_reg <= 1'b0;
            end
            if (arm_ok) begin
                lock_reg <= 1'b1;
            end else if (wr_ok) begin
                lock_reg <= 1'b0;
            end
            if (ovf_hit) begin
                ovf_reg <= 1'b1;
            end else if (arm_ok) begin
                ovf_reg <= 1'b0;
            end
        end
    end

    // Direct field and bus-cycle stamp
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dir_reg <= trp_pkg::DIR_EMPTY;
            ts_reg <= '0;
        end else if (entry || !in_run) begin
            dir_reg <= trp_pkg::DIR_EMPTY;
            ts_reg <= '0;
        end else begin
            dir_reg <= dir_in;
            ts_reg <= ts_reg + 16'h0001;
        end
    end

    // Buffer storage, kept across every reset
    always_ff @(posedge ref_clk) begin
        if (entry) begin
            mem[wp_reg[PW-1:0]] <= line_new;
        end
    end

    // Session pointers and count survive system reset
    wire tx_load = ~tx_busy & (pend != '0) & ~entry;
    always_ff @(posedge ref_clk or posedge por) begin
        if (por) begin
            wp_reg <= '0;
            txp_reg <= '0;
            wrap_reg <= 1'b0;
            cnt_reg <= '0;
        end else if (arm_ok) begin
            wp_reg <= '0;
            txp_reg <= '0;
            wrap_reg <= 1'b0;
            cnt_reg <= '0;
        end else begin
            if (entry) begin
                wp_reg <= wp_reg + 1'b1;
                if (wp_reg[PW-1:0] == PW'(LINES-1)) begin
                    wrap_reg <= 1'b1;
                end
                if (cnt_reg != trp_pkg::COUNT_MAX) begin
                    cnt_reg <= cnt_reg + 7'h01;
                end
            end
            if (tx_load) begin
                txp_reg <= txp_reg + 1'b1;
            end
        end
    end

    // Read-out path
    wire [PW-1:0] oldest = wrap_reg ? wp_reg[PW-1:0] : '0;
    logic push_ready;
    wire rd_take = rd_req & push_ready;
    wire rd_ok = rd_take & rd_word & ~rd_misaligned &
        ~armed_reg & ~lock_reg &
        trace_source_select &
        ~code_enable_a &
        ~tx_active;
    wire [LW-1:0] rd_line = mem[rdp_reg];
    // Low word of the line goes out first
    wire [15:0] rd_sel = rd_line[half_reg*trp_pkg::WORD_W +: 16];
    wire [15:0] rd_push = rd_ok ? rd_sel : trp_pkg::LOCKED_WORD;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdp_reg <= '0;
            half_reg <= '0;
        end else if (wr_ok || disarm_evt) begin
            rdp_reg <= oldest;
            half_reg <= '0;
        end else if (rd_ok) begin
            half_reg <= half_reg + 2'h1;
            if (half_reg == trp_pkg::WORD_LAST) begin
                // Natural wrap back to line zero
                rdp_reg <= rdp_reg + 1'b1;
            end
        end
    end

    trp_skid #(
        .W(16),
        .DEPTH(2)
    ) u_skid (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(rd_take),
        .in_ready(push_ready),
        .in_data(rd_push),
        .out_valid(rd_valid),
        .out_ready(rd_accept),
        .out_data(rd_data)
    );

    // Serial transmitter
    wire [LW-1:0] tx_line = mem[txp_reg[PW-1:0]];
    wire [3:0] tx_fmt = tx_line[3:0];
    // Only the bytes used by each format go out
    wire [6:0] tx_bits = (tx_fmt == trp_pkg::FMT_START) ?
        trp_pkg::BITS_START :
        (tx_fmt == trp_pkg::FMT_FULL) ? trp_pkg::BITS_FULL :
        (tx_fmt == trp_pkg::FMT_WRAPUP) ? trp_pkg::BITS_WRAPUP :
        trp_pkg::BITS_LINE;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sh_reg <= '0;
            bits_reg <= '0;
            phase_reg <= 1'b0;
            clk_reg <= 1'b0;
            pdo_reg <= 1'b0;
            oe_n_reg <= 1'b1;
        end else begin
            oe_n_reg <= ~code_enable_a_pin_enable;
            if (tx_load) begin
                // Info byte sits in the low bits, so it leaves first
                sh_reg <= tx_line;
                bits_reg <= tx_bits;
                phase_reg <= 1'b0;
            end else if (tx_busy) begin
                phase_reg <= ~phase_reg;
                if (!phase_reg) begin
                    pdo_reg <= sh_reg[0] & code_enable_a_pin_enable;
                end else begin
                    // Edge lands mid-bit, one per data bit
                    clk_reg <= ~clk_reg;
                    sh_reg <= {1'b0, sh_reg[LW-1:1]};
                    bits_reg <= bits_reg - 7'h01;
                end
            end
            // Clock holds its level while idle between lines
        end
    end

    assign armed = armed_reg;
    assign transmit_active_flag = tx_active;
    assign code_enable_a_overflow_flag = ovf_reg;
    assign valid_line_count = cnt_reg;
    assign code_enable_a_data_out = pdo_reg;
    assign code_enable_a_clock_out = clk_reg;
    assign code_enable_a_oe_n = oe_n_reg;
    assign rd_ready = push_ready;
endmodule
`default_nettype wire

// *** pkg/trp_pkg.sv ***
// Package: constants and types for trace read-out and code profiling
`default_nettype none
package trp_pkg;
    localparam int LINES = 64;
    localparam int PTR_W = 6;
    localparam int LINE_W = 64;
    localparam int WORD_W = 16;
    localparam logic [15:0] LOCKED_WORD = 16'h00ee;
    localparam logic [3:0] FMT_START = 4'h0;
    localparam logic [3:0] FMT_INDEXED = 4'h1;
    localparam logic [3:0] FMT_FULL = 4'h2;
    localparam logic [3:0] FMT_VECTOR = 4'h3;
    localparam logic [3:0] FMT_WRAPUP = 4'h7;
    localparam logic [6:0] BITS_START = 7'h20;
    localparam logic [6:0] BITS_FULL = 7'h28;
    localparam logic [6:0] BITS_WRAPUP = 7'h38;
    localparam logic [6:0] BITS_LINE = 7'h40;
    localparam logic [1:0] ALIGN_END = 2'h0;
    localparam logic [1:0] ALIGN_BEGIN = 2'h1;
    localparam logic [1:0] ALIGN_MID = 2'h2;
    localparam logic [15:0] STAMP_MAX = 16'hffff;
    localparam logic [31:0] DIR_EMPTY = 32'h0000_0001;
    localparam logic [6:0] PEND_LAST = 7'h3f;
    localparam logic [6:0] COUNT_MAX = 7'h40;
    localparam logic [1:0] WORD_LAST = 2'h3;
    typedef struct packed {
        logic branch;
        logic taken;
        logic indexed;
        logic vector;
        logic [23:0] target;
        logic [7:0] vec_addr;
    } trp_cof_t;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} trp_state_t;
endpackage
`default_nettype wire

// *** verif/test_trp_top.sv ***
// Self-checking bench for trace read-out and code profiling
`timescale 1ns/1ps
`default_nettype none
module test_trp_top;
    logic ref_clk, rst, por, trace_source_select, code_enable_a;
    logic code_enable_a_pin_enable, arm_req, disarm_req, final_state, rd_req;
    logic rd_word, rd_misaligned, rd_accept, wr_req, wr_word, rd_ready;
    logic rd_valid, armed, transmit_active_flag, code_enable_a_overflow_flag;
    logic code_enable_a_data_out, code_enable_a_clock_out, code_enable_a_oe_n;
    logic [1:0] trigger_alignment;
    trp_pkg::trp_cof_t change_of_flow;
    logic [23:0] pc_start;
    logic [15:0] rd_data, d;
    logic [6:0] valid_line_count;
    int miscompares = 0;
    int n_checks = 0;
    localparam logic [23:0] PC = 24'h3a5c71;
    localparam logic [23:0] TGT = 24'h12d4e6;
    localparam logic [15:0] W0 = {PC[7:0], 8'h00};
    localparam logic [15:0] LK = trp_pkg::LOCKED_WORD;
    trp_top u_dut (.*);
    trp_tool u_tool (.*);
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic rd(input logic w, input logic m, output logic [15:0] q);
        int n;
        n = 0;
        @(posedge ref_clk);
        rd_req <= 1'b1;
        rd_word <= w;
        rd_misaligned <= m;
        @(posedge ref_clk);
        rd_req <= 1'b0;
        #1;
        while (rd_valid !== 1'b1 && n < 20) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= 20) begin
            miscompares++;
        end
        q = rd_data;
        @(posedge ref_clk);
    endtask
    task automatic wr();
        @(posedge ref_clk);
        wr_req <= 1'b1;
        @(posedge ref_clk);
        wr_req <= 1'b0;
    endtask
    task automatic pulse(input int k);
        @(posedge ref_clk);
        arm_req <= (k == 0);
        disarm_req <= (k == 1);
        @(posedge ref_clk);
        arm_req <= 1'b0;
        disarm_req <= 1'b0;
    endtask
    task automatic flow(input logic b, input logic t, input logic x);
        @(posedge ref_clk);
        change_of_flow <= {b, t, x, 1'b0, TGT, 8'h00};
        @(posedge ref_clk);
        change_of_flow <= '0;
    endtask
    function automatic logic [15:0] rx_bits(input int at, input int n);
        logic [15:0] v;
        v = '0;
        for (int i = 0; i < n; i++) v[i] = u_tool.rx[at + i];
        return v;
    endfunction
    task automatic t_code_enable_a();
        pulse(0);
        tick(4);
        chk(16'(armed), 16'h0001);
        flow(1'b1, 1'b1, 1'b0);
        flow(1'b1, 1'b0, 1'b0);
        flow(1'b0, 1'b0, 1'b1);
        tick(6);
        pulse(1);
        chk(16'(transmit_active_flag), 16'h0001);
        rd(1'b1, 1'b0, d);
        chk(d, LK);
        for (int i = 0; i < 3000; i++) begin
            if (transmit_active_flag === 1'b0) break;
            tick(1);
        end
        code_enable_a <= 1'b0;
        chk(16'(valid_line_count), 16'h0003);
        chk(16'(u_tool.rx.size()), 16'd152);
        chk(rx_bits(0, 8), 16'h0000);
        chk(rx_bits(8, 16), PC[15:0]);
        chk(rx_bits(24, 8), {8'h00, PC[23:16]});
        chk(rx_bits(32, 8), 16'h0001);
        chk(rx_bits(40, 8), 16'h0006);
        chk(rx_bits(72, 16), TGT[15:0]);
        chk(rx_bits(96, 8), 16'h0017);
    endtask
    task automatic t_readout();
        wr();
        rd(1'b1, 1'b0, d);
        chk(d, W0);
        rd(1'b1, 1'b0, d);
        chk(d, PC[23:8]);
        tick(1);
        repeat (2) rd(1'b1, 1'b0, d);
        rd(1'b1, 1'b0, d);
        chk(d, 16'h0601);
        repeat (4 * trp_pkg::LINES - 5) rd(1'b1, 1'b0, d);
        rd(1'b1, 1'b0, d);
        chk(d, W0);
        chk(16'(valid_line_count), 16'h0003);
    endtask
    task automatic t_refuse();
        wr();
        rd(1'b1, 1'b1, d);
        chk(d, LK);
        rd(1'b0, 1'b0, d);
        chk(d, LK);
        code_enable_a <= 1'b1;
        rd(1'b1, 1'b0, d);
        chk(d, LK);
        code_enable_a <= 1'b0;
        rd(1'b1, 1'b0, d);
        chk(d, W0);
    endtask
    task automatic t_sysreset();
        @(posedge ref_clk);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        chk(16'(valid_line_count), 16'h0003);
        wr();
        rd(1'b1, 1'b0, d);
        chk(d, W0);
    endtask
    task automatic t_locked();
        pulse(0);
        rd(1'b1, 1'b0, d);
        chk(d, LK);
        rd_accept <= 1'b0;
        @(posedge ref_clk);
        rd_req <= 1'b1;
        tick(3);
        #1;
        rd_req <= 1'b0;
        chk(16'(rd_ready), 16'h0000);
        chk(rd_data, LK);
        rd_accept <= 1'b1;
        tick(3);
        #1;
        chk(16'(rd_valid), 16'h0000);
        pulse(1);
        rd(1'b1, 1'b0, d);
        chk(d, LK);
    endtask
    task automatic t_vector();
        code_enable_a <= 1'b1;
        trigger_alignment <= trp_pkg::ALIGN_BEGIN;
        pulse(0);
        tick(4);
        chk(16'(transmit_active_flag), 16'h0000);
        @(posedge ref_clk);
        final_state <= 1'b1;
        @(posedge ref_clk);
        final_state <= 1'b0;
        tick(2);
        @(posedge ref_clk);
        change_of_flow <= {4'h1, 24'h00_0000, 8'h5a};
        @(posedge ref_clk);
        change_of_flow <= '0;
        tick(6);
        pulse(1);
        for (int i = 0; i < 3000; i++) begin
            if (transmit_active_flag === 1'b0) break;
            tick(1);
        end
        chk(16'(valid_line_count), 16'h0003);
        chk(16'(u_tool.rx.size()), 16'd304);
        chk(rx_bits(184, 8), 16'h0003);
        chk(rx_bits(240, 8), 16'h005a);
    endtask
    initial begin
        rst = 1'b1;
        por = 1'b1;
        trace_source_select = 1'b1;
        code_enable_a = 1'b1;
        code_enable_a_pin_enable = 1'b1;
        trigger_alignment = trp_pkg::ALIGN_MID;
        {arm_req, disarm_req, final_state, rd_req} = 4'h0;
        {rd_word, rd_misaligned, wr_req} = 3'h0;
        rd_accept = 1'b1;
        wr_word = 1'b1;
        change_of_flow = '0;
        pc_start = PC;
        tick(5);
        rst <= 1'b0;
        por <= 1'b0;
        t_code_enable_a();
        t_readout();
        t_refuse();
        t_sysreset();
        t_locked();
        t_vector();
        report_and_stop();
    end
    initial begin
        #400000;
        miscompares++;
        report_and_stop();
    end
endmodule
bind trp_top trp_sva u_sva (.*);
`default_nettype wire

// *** verif/trp_sva.sv ***
// Checker of the read port and profiling pin relations
`timescale 1ns/1ps
`default_nettype none
module trp_sva (
    input wire logic ref_clk, // Bus clock
    input wire logic rst, // System reset
    input wire logic por, // Power-on reset
    input wire logic code_enable_a, // Code_enable_a enable
    input wire logic code_enable_a_pin_enable, // Pin enable
    input wire logic arm_req, // Arm pulse
    input wire logic rd_req, // Read request
    input wire logic rd_word, // Word read
    input wire logic rd_misaligned, // Odd address
    input wire logic rd_ready, // Read room
    input wire logic rd_valid, // Read data held
    input wire logic [15:0] rd_data, // Read data
    input wire logic armed, // Unit armed
    input wire logic transmit_active_flag, // Lines still to send
    input wire logic code_enable_a_overflow_flag, // Overflow seen
    input wire logic [6:0] valid_line_count, // Valid lines
    input wire logic code_enable_a_data_out, // Serial data
    input wire logic code_enable_a_clock_out // Serial clock
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || por);
    wire logic take;
    assign take = rd_req && rd_ready && !rd_valid;
    property p_lock_armed;
        take && armed |=> rd_valid && rd_data == trp_pkg::LOCKED_WORD;
    endproperty
    a_lock_armed: assert property (p_lock_armed)
        else $error("armed read not refused");
    property p_lock_size;
        take && (!rd_word || rd_misaligned) |=>
            rd_valid && rd_data == trp_pkg::LOCKED_WORD;
    endproperty
    a_lock_size: assert property (p_lock_size)
        else $error("byte or odd read not refused");
    property p_lock_prof;
        take && code_enable_a |=> rd_data == trp_pkg::LOCKED_WORD;
    endproperty
    a_lock_prof: assert property (p_lock_prof)
        else $error("read during code_enable_a enable not refused");
    property p_lock_busy;
        take && !armed && transmit_active_flag |=>
            rd_data == trp_pkg::LOCKED_WORD;
    endproperty
    a_lock_busy: assert property (p_lock_busy)
        else $error("read while sending not refused");
    property p_count_hold;
        !armed [*3] ##0 !arm_req |=> $stable(valid_line_count);
    endproperty
    a_count_hold: assert property (p_count_hold)
        else $error("line count moved while disarmed");
    property p_clk_idle;
        !transmit_active_flag [*4] |-> $stable(code_enable_a_clock_out);
    endproperty
    a_clk_idle: assert property (p_clk_idle)
        else $error("code_enable_a clock moved with nothing to send");
    property p_clk_half;
        $changed(code_enable_a_clock_out) |=> $stable(code_enable_a_clock_out);
    endproperty
    a_clk_half: assert property (p_clk_half)
        else $error("code_enable_a clock faster than half rate");
    property p_data_half;
        $changed(code_enable_a_data_out) |=> $stable(code_enable_a_data_out);
    endproperty
    a_data_half: assert property (p_data_half)
        else $error("code_enable_a data faster than half rate");
    property p_pin_quiet;
        !code_enable_a_pin_enable && $past(!code_enable_a_pin_enable) |->
            !code_enable_a_data_out;
    endproperty
    a_pin_quiet: assert property (p_pin_quiet)
        else $error("code_enable_a data driven without pin enable");
    property p_ovf_sticky;
        code_enable_a_overflow_flag && !arm_req |=> code_enable_a_overflow_flag;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky)
        else $error("overflow flag dropped without arm");
endmodule
`default_nettype wire

// *** verif/trp_tool.sv ***
// Debug tool model gathering profiling bits on both clock edges
`timescale 1ns/1ps
`default_nettype none
module trp_tool (
    input wire logic rst, // System reset
    input wire logic code_enable_a_data_out, // Serial data
    input wire logic code_enable_a_clock_out, // Serial clock
    input wire logic code_enable_a_oe_n // Low while device drives
);
    logic rx[$];
    wire logic pin_level;
    // Pull-down when the pin is not driven
    assign pin_level = code_enable_a_oe_n ? 1'b0 : code_enable_a_data_out;
    always @(code_enable_a_clock_out) begin
        if (rst === 1'b0) begin
            rx.push_back(pin_level);
        end
    end
endmodule
`default_nettype wire
